// ==== hw/fes_status_ctrl.sv ====
/*
 Host-side monitor for embedded flash operations: polls the toggle and
 polling bits at the target address, classifies the three error kinds,
 reads the status register and clears an operation or abort error with the proper command.
 Assumes a user that starts a check after launching a program or erase.
*/
`timescale 1ns/1ps
module fes_status_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        check_start,
    input  wire logic [15:0] target_addr,
    input  wire logic [15:0] expect_data,
    input  wire logic        is_erase,
    input  wire logic [15:0] dq_in,
    input  wire logic        ready_busy_n,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic [15:0]      a_out,
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    output logic             check_done,
    output logic             check_ok,
    output logic [1:0]       err_kind,
    output logic [7:0]       status_seen,
    output logic             busy
);
    fes_pkg::fes_state_t st_r, st_nxt;
    logic [15:0] poll1_r, poll1_nxt, cmd_a, cmd_d;
    logic [2:0]  seq_r, seq_nxt;
    logic [15:0] wait_r, wait_nxt;
    logic [1:0]  kind_r, kind_nxt;
    logic [7:0]  sr_r, sr_nxt;
    logic        ok_r, ok_nxt, tmo_seen_r, tmo_seen_nxt, done_nxt;
    logic        cyc_start, cyc_write, cyc_done;
    logic [15:0] cyc_rdata, poll2;
    logic        tog1, tog2, inv_ok;

    fes_bus_cycle u_cyc (
        .clk    (clk),
        .rst    (rst),
        .start  (cyc_start),
        .write  (cyc_write),
        .addr   (cmd_a),
        .wdata  (cmd_d),
        .dq_in  (dq_in),
        .ce_n   (ce_n),
        .oe_n   (oe_n),
        .we_n   (we_n),
        .a_out  (a_out),
        .dq_out (dq_out),
        .dq_oe  (dq_oe),
        .rdata  (cyc_rdata),
        .done   (cyc_done)
    );

    // Compare two polls, reserved bits masked
    assign poll2  = cyc_rdata & fes_pkg::POLL_MASK; // R22
    assign tog1   = poll1_r[fes_pkg::TOGGLE1_BIT] ^ poll2[fes_pkg::TOGGLE1_BIT];
    assign tog2   = poll1_r[fes_pkg::TOGGLE2_BIT] ^ poll2[fes_pkg::TOGGLE2_BIT];
    // Polling bit matches true data once done; erase completes to one
    assign inv_ok = cyc_rdata[fes_pkg::POLL_INV_BIT] ==
                    (is_erase ? 1'b1 : expect_data[fes_pkg::POLL_INV_BIT]); // R23

    // Command address and data per state and step
    always_comb begin
        cmd_a     = target_addr; // R22
        cmd_d     = 16'h0000;
        cyc_write = 1'b0;
        if (st_r == fes_pkg::FES_SRCMD) begin
            cyc_write = 1'b1;
            cmd_a     = fes_pkg::ADDR_UNLOCK1;
            cmd_d     = fes_pkg::CMD_SR_READ;
        end else if (st_r == fes_pkg::FES_CLR) begin
            cyc_write = 1'b1;
            cmd_a     = fes_pkg::ADDR_UNLOCK1;
            cmd_d     = fes_pkg::CMD_SR_CLEAR; // R09 R17
            if (kind_r == fes_pkg::ERR_ABORT) begin
                // Abort-reset: two unlock cycles then reset code
                case (seq_r)
                    3'h0: begin cmd_a = fes_pkg::ADDR_UNLOCK1; cmd_d = fes_pkg::DATA_UNLOCK1; end
                    3'h1: begin cmd_a = fes_pkg::ADDR_UNLOCK2; cmd_d = fes_pkg::DATA_UNLOCK2; end
                    default: begin cmd_a = fes_pkg::ADDR_UNLOCK1; cmd_d = fes_pkg::CMD_RESET; end // R03
                endcase
            end else if (kind_r == fes_pkg::ERR_OP && tmo_seen_r) begin
                cmd_d = fes_pkg::CMD_RESET; // R02
            end
        end
    end

    // Main sequencer
    always_comb begin
        st_nxt       = st_r;
        poll1_nxt    = poll1_r;
        seq_nxt      = seq_r;
        wait_nxt     = wait_r;
        kind_nxt     = kind_r;
        sr_nxt       = sr_r;
        ok_nxt       = ok_r;
        tmo_seen_nxt = tmo_seen_r;
        done_nxt     = 1'b0;
        cyc_start    = 1'b0;
        case (st_r)
            fes_pkg::FES_IDLE: begin
                if (check_start) begin
                    kind_nxt     = fes_pkg::ERR_NONE;
                    tmo_seen_nxt = 1'b0;
                    ok_nxt       = 1'b0;
                    wait_nxt     = 16'h0000;
                    st_nxt       = fes_pkg::FES_RD1;
                end
            end
            fes_pkg::FES_RD1: begin
                cyc_start = 1'b1;
                if (cyc_done) begin
                    poll1_nxt = cyc_rdata & fes_pkg::POLL_MASK;
                    st_nxt    = fes_pkg::FES_RD2;
                end
            end
            fes_pkg::FES_RD2: begin
                cyc_start = 1'b1;
                if (cyc_done) begin
                    st_nxt = fes_pkg::FES_JUDGE;
                end
            end
            fes_pkg::FES_JUDGE: begin
                if (!tog1 && inv_ok) begin
                    // Clean polls; a refused write only shows in the status register
                    st_nxt = fes_pkg::FES_SRCMD; // R14
                end else if (tog1 && !tog2 && poll2[fes_pkg::ABORT_BIT]) begin
                    // A poll paired with array data can mimic abort; read again
                    if (tmo_seen_r) begin
                        kind_nxt = fes_pkg::ERR_ABORT; // R15
                        st_nxt   = fes_pkg::FES_SRCMD;
                    end else begin
                        tmo_seen_nxt = 1'b1;
                        st_nxt       = fes_pkg::FES_RD1;
                    end
                end else if (tog1 && poll2[fes_pkg::TIMEOUT_BIT]) begin
                    // Recheck once after timeout before declaring error
                    if (tmo_seen_r) begin
                        kind_nxt = fes_pkg::ERR_OP; // R06
                        st_nxt   = fes_pkg::FES_SRCMD;
                    end else begin
                        tmo_seen_nxt = 1'b1; // R23
                        st_nxt       = fes_pkg::FES_RD1;
                    end
                end else if (wait_r >= 16'(fes_pkg::PROT_BUSY_CYC) && tog1 && tog2) begin
                    kind_nxt = fes_pkg::ERR_PROTECT; // R11
                    st_nxt   = fes_pkg::FES_SRCMD;
                end else begin
                    st_nxt = fes_pkg::FES_RD1;
                end
            end
            fes_pkg::FES_SRCMD: begin
                cyc_start = 1'b1; // R10 R13
                if (cyc_done) begin
                    st_nxt = fes_pkg::FES_SRRD;
                end
            end
            fes_pkg::FES_SRRD: begin
                cyc_start = 1'b1; // R18
                if (cyc_done) begin
                    sr_nxt  = cyc_rdata[7:0];
                    seq_nxt = 3'h0;
                    ok_nxt  = 1'b0;
                    if (kind_r == fes_pkg::ERR_NONE) begin
                        // Protect bit left after the busy period marks a refused write
                        if (cyc_rdata[fes_pkg::SR_PROTECT_BIT]) begin
                            kind_nxt = fes_pkg::ERR_PROTECT; // R14
                        end else begin
                            ok_nxt = 1'b1;
                        end
                        st_nxt = fes_pkg::FES_DONE;
                    end else begin
                        // Protection status clears itself; nothing to write
                        st_nxt = (kind_r == fes_pkg::ERR_PROTECT) ? fes_pkg::FES_WAIT : fes_pkg::FES_CLR; // R14
                    end
                end
            end
            fes_pkg::FES_CLR: begin
                cyc_start = 1'b1;
                if (cyc_done) begin
                    if (kind_r == fes_pkg::ERR_ABORT && seq_r != 3'h2) begin
                        seq_nxt = seq_r + 3'h1;
                    end else begin
                        wait_nxt = 16'h0000;
                        st_nxt   = fes_pkg::FES_WAIT;
                    end
                end
            end
            fes_pkg::FES_WAIT: begin
                // Hold off new commands until ready returns
                if (ready_busy_n) begin
                    st_nxt = fes_pkg::FES_DONE; // R24
                end
            end
            fes_pkg::FES_DONE: begin
                done_nxt = 1'b1;
                st_nxt   = fes_pkg::FES_IDLE;
            end
            default: st_nxt = fes_pkg::FES_IDLE;
        endcase
        if (st_r != fes_pkg::FES_IDLE && st_r != fes_pkg::FES_DONE && wait_r != 16'hFFFF) begin
            wait_nxt = wait_nxt + 16'h0001;
        end
    end

    // Registers; user outputs straight from flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= fes_pkg::FES_IDLE; poll1_r <= 16'h0000; seq_r <= 3'h0;
            wait_r <= 16'h0000; kind_r <= fes_pkg::ERR_NONE; sr_r <= 8'h00;
            ok_r <= 1'b0; tmo_seen_r <= 1'b0;
            check_done <= 1'b0; check_ok <= 1'b0; err_kind <= 2'h0;
            status_seen <= 8'h00; busy <= 1'b0;
        end else begin
            st_r <= st_nxt; poll1_r <= poll1_nxt; seq_r <= seq_nxt;
            wait_r <= wait_nxt; kind_r <= kind_nxt; sr_r <= sr_nxt;
            ok_r <= ok_nxt; tmo_seen_r <= tmo_seen_nxt;
            check_done  <= done_nxt;
            check_ok    <= ok_nxt;
            err_kind    <= kind_nxt;
            status_seen <= sr_nxt;
            busy        <= (st_nxt != fes_pkg::FES_IDLE);
        end
    end

    // Steps of the abort-reset sequence
    sequence s_abort_unlock;
        st_r == fes_pkg::FES_CLR && kind_r == fes_pkg::ERR_ABORT && seq_r == 3'h0 && cyc_done;
    endsequence
    sequence s_abort_second;
        st_r == fes_pkg::FES_CLR && seq_r == 3'h1;
    endsequence

    // Checks on the host's own behaviour
    a_abort_steps: assert property (@(posedge clk) disable iff (rst) // R03
        s_abort_unlock |=> s_abort_second)
        else $error("abort clear skipped its second unlock step");
    a_bus_cmd: assert property (@(posedge clk) disable iff (rst) // R10
        !we_n |-> (dq_out == fes_pkg::CMD_SR_READ || dq_out == fes_pkg::CMD_SR_CLEAR ||
                   dq_out == fes_pkg::CMD_RESET || dq_out == fes_pkg::DATA_UNLOCK1 ||
                   dq_out == fes_pkg::DATA_UNLOCK2))
        else $error("command written that the device refuses in error");
    a_wait_ready: assert property (@(posedge clk) disable iff (rst)
        (st_r == fes_pkg::FES_WAIT && !ready_busy_n) |=> !cyc_start) // R24
        else $error("command issued while device busy after clear");
    a_abort_clear: assert property (@(posedge clk) disable iff (rst)
        (st_r == fes_pkg::FES_CLR && kind_r == fes_pkg::ERR_ABORT && seq_r == 3'h2) |->
        cmd_d == fes_pkg::CMD_RESET) // R03
        else $error("abort clear does not end with reset code");
    a_tmo_recheck: assert property (@(posedge clk) disable iff (rst)
        (st_r == fes_pkg::FES_JUDGE && kind_nxt == fes_pkg::ERR_OP && kind_r != fes_pkg::ERR_OP) |-> tmo_seen_r) // R23
        else $error("timeout declared without recheck");
    a_target_addr: assert property (@(posedge clk) disable iff (rst)
        (cyc_start && (st_r == fes_pkg::FES_RD1 || st_r == fes_pkg::FES_RD2)) |-> cmd_a == target_addr) // R22
        else $error("poll read not at target address");
endmodule : fes_status_ctrl

// ==== hw/fes_pkg.sv ====
/*
 Package for the flash status-monitor controller: command codes, status bit
 positions, error classes, timing counts and the controller state type.
 Assumes a 16-bit asynchronous flash bus driven at a 200 MHz controller clock.
*/
// Behaviour
// R01: Device raises timeout_flag when program or erase exceeds its pulse limit.
// R02: Host clears timeout with reset; device may stay busy up to 2 us.
// R03: Device raises buffer_abort_flag on buffer abort; host issues abort-reset.
// R04: Clearing an error returns device to its prior state.
// R05: On operation error device stays busy, overlays polling, status valid.
// R06: In error, timeout_flag one, toggles run, erase timer and abort flag one.
// R07: In error, polling_inverse_bit is inverted data, zero for erase.
// R08: Error status register: bit7, bit5 erase, bit4 program, bits 3..1 set.
// R09: Host clears operation error with reset or status clear; ready returns.
// R10: In error device accepts only status read, reset, status clear.
// R11: Protection violation busies device 20 to 100 us with status bit7 zero.
// R12: Protection busy polling: timeout zero, toggles run, timer and abort one.
// R13: During protection busy only status register read is accepted.
// R14: After protection busy ready returns; status shows bit7, bit1, bits 3,2 clear.
// R15: Buffer abort busy: timeout zero, toggle one runs, toggle two static.
// R16: Buffer abort status register: bits 7,4,3 set; bits 5,2,1 clear.
// R17: Host clears buffer abort with abort-reset or status clear.
// R18: Status read during buffer abort returns register, error stays.
// R19: Erasing sector reads: inverse zero, toggles run, timer one, busy low.
// R20: Program suspend: suspended line invalid, elsewhere array data, ready high.
// R21: Erase suspend: other sectors read array data with ready high.
// R22: Host gives valid target address and masks polling bits 4 and 0.
// R23: Host rechecks polling_inverse_bit even after timeout_flag is seen.
// R24: After reset for timeout, host waits for ready before new commands.
package fes_pkg;
    // Polling bit positions
    localparam int POLL_INV_BIT  = 7;
    localparam int TOGGLE1_BIT   = 6;
    localparam int TIMEOUT_BIT   = 5;
    localparam int ERASE_TMR_BIT = 3;
    localparam int TOGGLE2_BIT   = 2;
    localparam int ABORT_BIT     = 1;
    localparam logic [15:0] POLL_MASK = 16'h00EE;
    // Status register bit positions
    localparam int SR_READY_BIT   = 7;
    localparam int SR_ERASE_BIT   = 5;
    localparam int SR_PROG_BIT    = 4;
    localparam int SR_ABORT_BIT   = 3;
    localparam int SR_SUSP_BIT    = 2;
    localparam int SR_PROTECT_BIT = 1;
    // Command cycles
    localparam logic [15:0] ADDR_UNLOCK1 = 16'h0555;
    localparam logic [15:0] ADDR_UNLOCK2 = 16'h02AA;
    localparam logic [15:0] DATA_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] DATA_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_RESET    = 16'h00F0;
    localparam logic [15:0] CMD_SR_READ  = 16'h0070;
    localparam logic [15:0] CMD_SR_CLEAR = 16'h0071;
    // Error classes reported to the user
    localparam logic [1:0] ERR_NONE    = 2'h0;
    localparam logic [1:0] ERR_OP      = 2'h1;
    localparam logic [1:0] ERR_PROTECT = 2'h2;
    localparam logic [1:0] ERR_ABORT   = 2'h3;
    // Timing
    localparam int CLK_MHZ          = 200;
    localparam int BUS_NS           = 70;
    localparam int BUS_CYC          = (BUS_NS * CLK_MHZ + 999) / 1000;
    localparam int CLEAR_BUSY_US    = 2;
    localparam int CLEAR_BUSY_CYC   = CLEAR_BUSY_US * CLK_MHZ;
    localparam int PROT_BUSY_MAX_US = 100;
    localparam int PROT_BUSY_CYC    = PROT_BUSY_MAX_US * CLK_MHZ;
    localparam int CNT_W            = 16;
    typedef enum logic [3:0] {
        FES_IDLE  = 4'h0,
        FES_RD1   = 4'h1,
        FES_RD2   = 4'h3,
        FES_JUDGE = 4'h2,
        FES_SRCMD = 4'h6,
        FES_SRRD  = 4'h7,
        FES_CLR   = 4'h5,
        FES_WAIT  = 4'h4,
        FES_DONE  = 4'hC
    } fes_state_t;
endpackage : fes_pkg

// ==== hw/fes_bus_cycle.sv ====
/*
 One asynchronous flash bus cycle, read or write, with fixed strobe width.
 Assumes the flash samples on the strobe's rising edge.
*/
`timescale 1ns/1ps
module fes_bus_cycle (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        write,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] dq_in,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic [15:0]      a_out,
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    output logic [15:0]      rdata,
    output logic             done
);
    logic [7:0]  cnt_r, cnt_nxt;
    logic        busy_r, busy_nxt, wr_r, wr_nxt, done_nxt;
    logic [15:0] a_nxt, d_nxt, rd_nxt;

    // Next-state of a single strobe
    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        wr_nxt   = wr_r;
        a_nxt    = a_out;
        d_nxt    = dq_out;
        rd_nxt   = rdata;
        done_nxt = 1'b0;
        // Not in the done cycle: the caller still holds start while it moves on
        if (!busy_r && !done && start) begin
            busy_nxt = 1'b1;
            wr_nxt   = write;
            a_nxt    = addr;
            d_nxt    = wdata;
            cnt_nxt  = 8'(fes_pkg::BUS_CYC);
        end else if (busy_r) begin
            if (cnt_r == 8'h00) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                rd_nxt   = dq_in; // Sample before strobe rises
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
        end
    end

    // Registers; strobes are flops for clean edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00; busy_r <= 1'b0; wr_r <= 1'b0;
            a_out <= 16'h0000; dq_out <= 16'h0000; rdata <= 16'h0000; done <= 1'b0;
            ce_n <= 1'b1; oe_n <= 1'b1; we_n <= 1'b1; dq_oe <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt; busy_r <= busy_nxt; wr_r <= wr_nxt;
            a_out <= a_nxt; dq_out <= d_nxt; rdata <= rd_nxt; done <= done_nxt;
            ce_n  <= ~busy_nxt;
            oe_n  <= ~(busy_nxt & ~wr_nxt);
            we_n  <= ~(busy_nxt & wr_nxt);
            dq_oe <= busy_nxt & wr_nxt;
        end
    end
endmodule : fes_bus_cycle

// ==== tb/fes_flash_model.sv ====
/*
 Behavioural flash device: polling overlay, three error states, status register.
 Assumes the bench sets mode and pulses launch to start an embedded operation.
*/
`timescale 1ns/1ps
module fes_flash_model #(
    parameter int PROT_NS = 60000,
    parameter int CLR_NS  = 400
) (
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [15:0] a_out,
    input  wire logic [15:0] dq_out,
    input  wire logic [1:0]  mode,
    input  wire logic        is_erase,
    input  wire logic [15:0] prog_data,
    input  wire logic        launch,
    output logic [15:0]      dq_in,
    output logic             ready_busy_n
);
    logic        ovl;
    logic        srd;
    logic        t1;
    logic        t2;
    logic [7:0]  sr;
    logic [1:0]  ul;
    logic [15:0] last;
    logic [15:0] poll;
    logic [15:0] cur;
    int          polls;

    // Idle device
    initial begin
        ovl = 1'b0;
        srd = 1'b0;
        t1 = 1'b0;
        t2 = 1'b0;
        sr = 8'h80;
        ul = 2'h0;
        last = 16'h0000;
        polls = 0;
        ready_busy_n = 1'b1;
    end

    // Overlaid polling word
    assign poll = {8'h00, is_erase ? 1'b0 : ~prog_data[7], t1, mode == 2'h1, 1'b0, 1'b1, t2, 1'b1, 1'b0};
    // Read word; a released bus shows the inverse of the last word
    assign cur = srd ? {8'h00, sr} : ovl ? poll : is_erase ? 16'hFFFF : prog_data;
    assign dq_in = oe_n ? ~last : cur;

    // Operation start; a protection error ends by itself
    always @(posedge launch) begin
        ovl = 1'b1;
        ready_busy_n = 1'b0;
        polls = 0;
        ul = 2'h0;
        sr = (mode == 2'h2) ? 8'h00 : (mode == 2'h3) ? 8'h98 : (mode == 2'h1) ? (is_erase ? 8'hAE : 8'h9E) : 8'h80;
        if (mode == 2'h2) begin
            #(PROT_NS);
            sr = is_erase ? 8'hA2 : 8'h92;
            ovl = 1'b0;
            ready_busy_n = 1'b1;
        end
    end

    // End of an overlaid read advances toggle one, and toggle two except in abort mode
    always @(posedge oe_n) begin
        last = cur;
        if (srd) begin
            srd = 1'b0;
        end
        else if (ovl) begin
            t1 = ~t1;
            if (mode != 2'h3) begin
                t2 = ~t2;
            end
            polls++;
            if (mode == 2'h0 && polls >= 3) begin
                ovl = 1'b0;
                ready_busy_n = 1'b1;
            end
        end
    end

    // Command decode; only status read, reset and clear act while in error
    always @(posedge we_n) begin
        if (a_out == fes_pkg::ADDR_UNLOCK1 && dq_out == fes_pkg::CMD_SR_READ) begin
            srd = 1'b1;
        end
        else if (ovl && mode != 2'h2 && mode != 2'h0) begin
            if (dq_out == fes_pkg::CMD_SR_CLEAR || (dq_out == fes_pkg::CMD_RESET && (mode == 2'h1 || ul == 2'h2))) begin
                ovl = 1'b0;
                sr = 8'h80;
                ready_busy_n <= #(CLR_NS) 1'b1;
            end
            else if (dq_out == fes_pkg::DATA_UNLOCK1 && a_out == fes_pkg::ADDR_UNLOCK1) begin
                ul = 2'h1;
            end
            else if (dq_out == fes_pkg::DATA_UNLOCK2 && a_out == fes_pkg::ADDR_UNLOCK2 && ul == 2'h1) begin
                ul = 2'h2;
            end
        end
    end
endmodule : fes_flash_model

// ==== tb/test_fes_status_ctrl.sv ====
/*
 Self-checking bench: status controller against the flash device model.
 Assumes the device model in fes_flash_model.sv.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module test_fes_status_ctrl;
    logic        clk;
    logic        rst;
    logic        check_start;
    logic        is_erase;
    logic        launch;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe;
    logic        ready_busy_n;
    logic        check_done;
    logic        check_ok;
    logic        busy;
    logic [1:0]  mode;
    logic [1:0]  err_kind;
    logic [7:0]  status_seen;
    logic [15:0] target_addr;
    logic [15:0] expect_data;
    logic [15:0] prog_data;
    logic [15:0] a_out;
    logic [15:0] dq_out;
    logic [15:0] dq_dev;
    logic [15:0] dq_bus;
    logic [31:0] seed;
    int          failures;
    int          checks;
    int          n;
    int          modes [7] = '{0, 1, 1, 3, 2, 2, 0};
    int          erases [7] = '{0, 0, 1, 0, 0, 1, 0};

    // Shared data wire
    assign dq_bus = dq_oe ? dq_out : dq_dev;

    fes_status_ctrl i_fes_status_ctrl (
        .clk(clk), .rst(rst), .check_start(check_start), .target_addr(target_addr),
        .expect_data(expect_data), .is_erase(is_erase), .dq_in(dq_bus), .ready_busy_n(ready_busy_n),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a_out(a_out), .dq_out(dq_out), .dq_oe(dq_oe),
        .check_done(check_done), .check_ok(check_ok), .err_kind(err_kind), .status_seen(status_seen), .busy(busy)
    );

    fes_flash_model i_fes_flash_model (
        .oe_n(oe_n), .we_n(we_n), .a_out(a_out), .dq_out(dq_out), .mode(mode), .is_erase(is_erase),
        .prog_data(prog_data), .launch(launch), .dq_in(dq_dev), .ready_busy_n(ready_busy_n)
    );

    // Clock
    always #2.5 clk = ~clk;

    // Random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    // Expected status register seen after each error kind
    function automatic logic [7:0] exp_sr(input int m, input int er);
        int v = 128;
        if (m == 1) v += 14 + (er ? 32 : 16);
        if (m == 2) v += 2 + (er ? 32 : 16);
        if (m == 3) v += 24;
        return v[7:0];
    endfunction : exp_sr

    // Verdict and end of run
    task automatic end_of_test();
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end
        else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // Hang guard
    initial begin
        #(400000);
        failures++;
        end_of_test();
    end

    // Scenarios: success, timeout, erase timeout, abort, protection, erase protection
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        check_start = 1'b0;
        is_erase = 1'b0;
        launch = 1'b0;
        mode = 2'h0;
        target_addr = 16'h0000;
        expect_data = 16'h0000;
        prog_data = 16'h0000;
        seed = 32'h3e3e9316;
        failures = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            seed = xs(seed);
            @(posedge clk);
            mode <= modes[i][1:0];
            is_erase <= erases[i][0];
            prog_data <= seed[15:0];
            expect_data <= seed[15:0];
            target_addr <= seed[31:16];
            launch <= 1'b1;
            @(posedge clk);
            launch <= 1'b0;
            check_start <= 1'b1;
            @(posedge clk);
            check_start <= 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (check_done !== 1'b1 && n < 40000);
            `CHK(check_done, 1'b1)
            `CHK(check_ok, modes[i] == 0)
            `CHK(err_kind, modes[i][1:0])
            `CHK(status_seen, exp_sr(modes[i], erases[i]))
            `CHK(ready_busy_n, 1'b1)
            @(posedge clk);
            #1;
            `CHK(check_done, 1'b0)
        end
        end_of_test();
    end
endmodule : test_fes_status_ctrl
